// [logic/drr_refresh.sv]
// DRAM refresh requester: parameter words, request capture and bus cycle issue.
// Assumes a shared bus unit runs the serial-DMA style cycle and reports done/error.
// What this block does
// - Each refresh is a serial-DMA style byte read bus cycle.
// - Bus-clear request asserted from the cycle after the refresh cycle starts until bus grant, as for serial DMA.
// - Start-high word: function code bits 14..12, high address bits 7..0.
// - Bus error on refresh writes 0x0001 to bus-error channel word 0x67C.
// - Shares error code with first receive channel, otherwise independent.
// - One refresh read cycle per pending request; requests accepted while one is pending add no cycle, except one accepted in the cycle that refresh starts.
// - Enable set: falling edge on request pin starts refresh; clear: ignored.
// - Parameter words cleared to zero at reset, written before use, always readable.
// - When each cycle starts the working pointer advances by the row step.
// - After row-count cycles the pointer wraps to the start address.
// - Working words hold next address and function code, start-word layout.
// - Working count holds cycles left; software zeroes it before enabling.
// - Start-low word gives lower 16 bits of the 24-bit start address.
// - Pending refresh is served ahead of serial channels and commands.
// - Odd address asserts lower strobe only; even asserts upper only.
// - No refresh cycle starts while reset, halt or bus error is active.
`timescale 1ns/10ps
`default_nettype none
module drr_refresh (
  // Clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  // Request pin and enable
  input  wire logic                   refresh_request_pin,
  input  wire logic                   ext_risc_request_enable,
  // Bus exceptions
  input  wire logic                   bus_exception,
  // Parameter RAM port
  input  wire drr_pkg::drr_pram_req_s pram_req,
  output logic [15:0]                 pram_rdata,
  // Bus cycle
  output drr_pkg::drr_bus_req_s       bus_req,
  output logic                        bus_clear_req,
  input  wire logic                   bus_grant,
  input  wire logic                   bus_done,
  input  wire logic                   bus_error,
  // Scheduler and error report
  output logic                        refresh_pending,
  output logic                        berr_wr,
  output logic [11:0]                 berr_addr,
  output logic [15:0]                 berr_data
);
  import drr_pkg::*;

  // ****************************************
  // Request capture
  // ****************************************
  logic       fall_pulse;
  logic       pend_q;
  drr_state_e state_q;
  drr_state_e state_d;

  drr_edge_sync u_sync (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .pin_in     (refresh_request_pin),
    .fall_pulse (fall_pulse)
  );

  wire accept_req = fall_pulse & ext_risc_request_enable;
  wire start_cyc  = (state_q == DRR_IDLE) & pend_q & ~bus_exception;
  wire cyc_end    = (state_q == DRR_CYC) & bus_done;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pend_q <= 1'b0;
    end else if (accept_req) begin
      pend_q <= 1'b1;
    end else if (start_cyc) begin
      pend_q <= 1'b0;
    end
  end

  assign refresh_pending = pend_q;

  // ****************************************
  // Parameter words
  // ****************************************
  logic [15:0] start_high_q;
  logic [15:0] start_low_q;
  logic [15:0] row_step_q;
  logic [15:0] row_total_q;
  logic [15:0] next_high_q;
  logic [15:0] next_low_q;
  logic [15:0] rows_left_q;
  logic [15:0] spare_q;

  wire wr_sh = pram_req.wr & (pram_req.addr == OFS_START_HIGH_FC);
  wire wr_sl = pram_req.wr & (pram_req.addr == OFS_START_LOW);
  wire wr_rs = pram_req.wr & (pram_req.addr == OFS_ROW_STEP);
  wire wr_rt = pram_req.wr & (pram_req.addr == OFS_ROW_TOTAL);
  wire wr_nh = pram_req.wr & (pram_req.addr == OFS_NEXT_HIGH_FC);
  wire wr_nl = pram_req.wr & (pram_req.addr == OFS_NEXT_LOW);
  wire wr_rl = pram_req.wr & (pram_req.addr == OFS_ROWS_LEFT);
  wire wr_sp = pram_req.wr & (pram_req.addr == OFS_SPARE_WORD);

  // Reload at zero count before the cycle
  wire reload = start_cyc & (rows_left_q == PARAM_RESET);

  wire [15:0] cur_high = reload ? start_high_q : next_high_q;
  wire [15:0] cur_low  = reload ? start_low_q : next_low_q;
  wire [15:0] cur_left = reload ? row_total_q : rows_left_q;

  // 24-bit address and advance
  wire [23:0] cur_addr  = {cur_high[HADDR_MSB:0], cur_low};
  wire [23:0] step_addr = cur_addr + {8'h00, row_step_q};

  logic [23:0] addr_q;
  logic [2:0]  fc_q;
  logic [15:0] left_q;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      start_high_q <= PARAM_RESET;
      start_low_q  <= PARAM_RESET;
      row_step_q   <= PARAM_RESET;
      row_total_q  <= PARAM_RESET;
      spare_q      <= PARAM_RESET;
    end else begin
      if (wr_sh) start_high_q <= pram_req.wdata & HIGH_WORD_MASK;
      if (wr_sl) start_low_q <= pram_req.wdata;
      if (wr_rs) row_step_q <= pram_req.wdata;
      if (wr_rt) row_total_q <= pram_req.wdata;
      if (wr_sp) spare_q <= pram_req.wdata;
    end
  end

  // Working words: software writes, or hardware update as each cycle starts
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      next_high_q <= PARAM_RESET;
      next_low_q  <= PARAM_RESET;
      rows_left_q <= PARAM_RESET;
      addr_q      <= 24'h00_0000;
      fc_q        <= 3'h0;
      left_q      <= PARAM_RESET;
    end else begin
      if (start_cyc) begin
        addr_q <= cur_addr;
        fc_q   <= cur_high[FC_MSB:FC_LSB];
        left_q <= cur_left;
        next_high_q <= {1'b0, cur_high[FC_MSB:FC_LSB], 4'h0, step_addr[23:16]};
        next_low_q  <= step_addr[15:0];
        rows_left_q <= cur_left - 16'h0001;
      end else begin
        if (wr_nh) next_high_q <= pram_req.wdata & HIGH_WORD_MASK;
        if (wr_nl) next_low_q <= pram_req.wdata;
        if (wr_rl) rows_left_q <= pram_req.wdata;
      end
    end
  end

  // ****************************************
  // Read back
  // ****************************************
  logic [15:0] rdata_d;
  assign rdata_d = (pram_req.addr == OFS_START_HIGH_FC) ? start_high_q :
                   (pram_req.addr == OFS_START_LOW)     ? start_low_q :
                   (pram_req.addr == OFS_ROW_STEP)      ? row_step_q :
                   (pram_req.addr == OFS_ROW_TOTAL)     ? row_total_q :
                   (pram_req.addr == OFS_NEXT_HIGH_FC)  ? next_high_q :
                   (pram_req.addr == OFS_NEXT_LOW)      ? next_low_q :
                   (pram_req.addr == OFS_ROWS_LEFT)     ? rows_left_q :
                   (pram_req.addr == OFS_SPARE_WORD)    ? spare_q : 16'h0000;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pram_rdata <= 16'h0000;
    end else if (pram_req.rd) begin
      pram_rdata <= rdata_d;
    end
  end

  // ****************************************
  // Bus cycle sequencer
  // ****************************************
  always_comb begin
    state_d = state_q;
    case (state_q)
      DRR_IDLE: begin
        if (start_cyc) state_d = DRR_REQ;
      end
      DRR_REQ: begin
        if (bus_grant) state_d = DRR_CYC;
      end
      DRR_CYC: begin
        if (bus_error) state_d = DRR_ERR;
        else if (bus_done) state_d = DRR_IDLE;
      end
      DRR_ERR: begin
        state_d = DRR_IDLE;
      end
      default: begin
        state_d = DRR_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q <= DRR_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Byte read: one strobe by address parity
  assign bus_req.valid = (state_q == DRR_REQ) | (state_q == DRR_CYC);
  assign bus_req.addr  = addr_q;
  assign bus_req.fc    = fc_q;
  assign bus_req.uds   = bus_req.valid & ~addr_q[0];
  assign bus_req.lds   = bus_req.valid & addr_q[0];
  assign bus_clear_req = (state_q == DRR_REQ);

  // Error report to the shared channel word
  assign berr_wr   = (state_q == DRR_ERR);
  assign berr_addr = OFS_BERR_CHANNEL;
  assign berr_data = BERR_CODE;

  // ****************************************
  // Checks
  // ****************************************
  property p_one_strobe;
    @(posedge ref_clk) disable iff (rst) bus_req.valid |-> (bus_req.uds ^ bus_req.lds);
  endproperty
  a_one_strobe: assert property (p_one_strobe) else $error("two strobes");

  property p_no_start_exc;
    @(posedge ref_clk) disable iff (rst) bus_exception |-> !start_cyc;
  endproperty
  a_no_start_exc: assert property (p_no_start_exc) else $error("start under exception");

  property p_disabled;
    @(posedge ref_clk) disable iff (rst) (!pend_q && !ext_risc_request_enable) |=> !pend_q;
  endproperty
  a_disabled: assert property (p_disabled) else $error("request while disabled");

  property p_berr;
    @(posedge ref_clk) disable iff (rst)
      (state_q == DRR_CYC && bus_error) |=> berr_wr && berr_data == 16'h0001 && berr_addr == 12'h67C;
  endproperty
  a_berr: assert property (p_berr) else $error("bus error not reported");

  property p_step;
    @(posedge ref_clk) disable iff (rst)
      start_cyc |=> {next_high_q[7:0], next_low_q} == addr_q + {8'h00, row_step_q};
  endproperty
  a_step: assert property (p_step) else $error("pointer not advanced");

  property p_reload;
    @(posedge ref_clk) disable iff (rst)
      (start_cyc && rows_left_q == 16'h0000) |=> addr_q == {$past(start_high_q[7:0]), $past(start_low_q)};
  endproperty
  a_reload: assert property (p_reload) else $error("no wrap to start");

  property p_count;
    @(posedge ref_clk) disable iff (rst) start_cyc |=> rows_left_q == left_q - 16'h0001;
  endproperty
  a_count: assert property (p_count) else $error("count not decremented");

  property p_clear;
    @(posedge ref_clk) disable iff (rst) start_cyc |=> bus_clear_req;
  endproperty
  a_clear: assert property (p_clear) else $error("no bus clear");

  property p_once;
    @(posedge ref_clk) disable iff (rst) start_cyc && !accept_req |=> !pend_q;
  endproperty
  a_once: assert property (p_once) else $error("request serviced twice");

  property p_fc;
    @(posedge ref_clk) disable iff (rst) start_cyc |=> next_high_q[14:12] == bus_req.fc;
  endproperty
  a_fc: assert property (p_fc) else $error("function code mismatch");

  property p_hold_req;
    @(posedge ref_clk) disable iff (rst)
      (state_q == DRR_REQ && !bus_grant) |=> bus_req.valid && bus_clear_req && $stable(bus_req.addr);
  endproperty
  a_hold_req: assert property (p_hold_req) else $error("request dropped before grant");

  property p_pend_set;
    @(posedge ref_clk) disable iff (rst) accept_req |=> pend_q;
  endproperty
  a_pend_set: assert property (p_pend_set) else $error("enabled request lost");

  property p_berr_pulse;
    @(posedge ref_clk) disable iff (rst) berr_wr |=> !berr_wr;
  endproperty
  a_berr_pulse: assert property (p_berr_pulse) else $error("error report repeated");

  c_cycle: cover property (@(posedge ref_clk) disable iff (rst) cyc_end);
  c_error: cover property (@(posedge ref_clk) disable iff (rst) berr_wr);
  c_wrap:  cover property (@(posedge ref_clk) disable iff (rst) reload);
  c_held:  cover property (@(posedge ref_clk) disable iff (rst) bus_exception && pend_q);
endmodule
`default_nettype wire

// [logic/drr_pkg.sv]
// Constants and carriers for the DRAM refresh requester.
// Assumes a single system clock; parameter words sit at even offsets in a byte-addressed RAM window.
package drr_pkg;

  // ****************************************
  // Parameter word offsets
  // ****************************************
  localparam logic [11:0] OFS_START_HIGH_FC = 12'h0570;
  localparam logic [11:0] OFS_START_LOW     = 12'h0572;
  localparam logic [11:0] OFS_ROW_STEP      = 12'h0574;
  localparam logic [11:0] OFS_ROW_TOTAL     = 12'h0576;
  localparam logic [11:0] OFS_NEXT_HIGH_FC  = 12'h0578;
  localparam logic [11:0] OFS_NEXT_LOW      = 12'h057A;
  localparam logic [11:0] OFS_ROWS_LEFT     = 12'h057C;
  localparam logic [11:0] OFS_SPARE_WORD    = 12'h057E;
  localparam logic [11:0] OFS_BERR_CHANNEL  = 12'h067C;

  // ****************************************
  // Field layout and values
  // ****************************************
  localparam int          FC_LSB          = 12;
  localparam int          FC_MSB          = 14;
  localparam int          HADDR_MSB       = 7;
  localparam logic [15:0] HIGH_WORD_MASK  = 16'h70FF;
  localparam logic [15:0] BERR_CODE       = 16'h0001;
  localparam logic [15:0] PARAM_RESET     = 16'h0000;

  typedef enum logic [1:0] {
    DRR_IDLE,
    DRR_REQ,
    DRR_CYC,
    DRR_ERR
  } drr_state_e;

  // Bus cycle request toward the shared bus unit
  typedef struct packed {
    logic        valid;
    logic [23:0] addr;
    logic [2:0]  fc;
    logic        uds;
    logic        lds;
  } drr_bus_req_s;

  // Parameter RAM access from the core
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [15:0] wdata;
  } drr_pram_req_s;

endpackage

// [logic/drr_edge_sync.sv]
// Two-stage synchroniser with falling edge detect.
// Assumes the pin is asynchronous to ref_clk.
`timescale 1ns/10ps
`default_nettype none
module drr_edge_sync (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // Pin and edge
  input  wire logic pin_in,
  output logic      fall_pulse
);
  logic meta_q;
  logic sync_q;
  logic last_q;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      last_q <= 1'b1;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign fall_pulse = last_q & ~sync_q;
endmodule
`default_nettype wire

// [verification/drr_bus_model.sv]
// Stand-in for the bus unit and PAL serving refresh cycles.
// Assumes the test sets the answer delay and error choice.
`timescale 1ns/10ps
`default_nettype none
module drr_bus_model (
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  // Test controls
  input  wire logic [3:0]            wait_cycles,
  input  wire logic                  err_en,
  // Bus side
  input  wire drr_pkg::drr_bus_req_s bus_req,
  input  wire logic                  bus_clear_req,
  output logic                       bus_grant,
  output logic                       bus_done,
  output logic                       bus_error
);
  import drr_pkg::*;
  // ****************************************
  // Grant, then end the cycle after a delay
  // ****************************************
  logic       busy_q;
  logic [3:0] cnt_q;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      busy_q    <= 1'b0;
      cnt_q     <= 4'h0;
      bus_grant <= 1'b0;
      bus_done  <= 1'b0;
      bus_error <= 1'b0;
    end else begin
      bus_grant <= 1'b0;
      bus_done  <= 1'b0;
      bus_error <= 1'b0;
      if (bus_req.valid && bus_clear_req && !busy_q && !bus_grant) begin
        bus_grant <= 1'b1;
        busy_q    <= 1'b1;
        cnt_q     <= wait_cycles;
      end else if (busy_q && cnt_q != 4'h0) begin
        cnt_q <= cnt_q - 4'h1;
      end else if (busy_q) begin
        busy_q    <= 1'b0;
        bus_done  <= !err_en;
        bus_error <= err_en;
      end
    end
  end
endmodule
`default_nettype wire

// [verification/test_drr_refresh.sv]
// Self-checking bench for the refresh requester.
// Assumes the bus model answers refresh cycles.
`timescale 1ns/10ps
`default_nettype none
module test_drr_refresh;
  import drr_pkg::*;
  localparam logic [23:0] START = 24'h12_FFFF;
  logic          ref_clk = 1'b0;
  logic          rst = 1'b1;
  logic          pin = 1'b1;
  logic          enable = 1'b0;
  logic          bus_exception = 1'b0;
  logic [3:0]    wait_cycles = 4'h0;
  logic          err_en = 1'b0;
  drr_pram_req_s pram_req = '0;
  drr_bus_req_s  bus_req;
  logic [15:0]   pram_rdata;
  logic [15:0]   berr_data;
  logic [11:0]   berr_addr;
  logic          bus_clear_req;
  logic          bus_grant;
  logic          bus_done;
  logic          bus_error;
  logic          refresh_pending;
  logic          berr_wr;
  logic          valid_prev = 1'b0;
  int            miscompares = 0;
  int            samples_checked = 0;
  int            cycles = 0;
  int            starts = 0;
  int            berr_hits = 0;

  drr_refresh i_dut (.ref_clk(ref_clk), .rst(rst), .refresh_request_pin(pin),
    .ext_risc_request_enable(enable), .bus_exception(bus_exception), .pram_req(pram_req),
    .pram_rdata(pram_rdata), .bus_req(bus_req), .bus_clear_req(bus_clear_req),
    .bus_grant(bus_grant), .bus_done(bus_done), .bus_error(bus_error),
    .refresh_pending(refresh_pending), .berr_wr(berr_wr), .berr_addr(berr_addr),
    .berr_data(berr_data));
  drr_bus_model i_bus (.ref_clk(ref_clk), .rst(rst), .wait_cycles(wait_cycles), .err_en(err_en),
    .bus_req(bus_req), .bus_clear_req(bus_clear_req), .bus_grant(bus_grant),
    .bus_done(bus_done), .bus_error(bus_error));

  always #2 ref_clk = ~ref_clk;

  // ****************************************
  // Shared checking and bus tasks
  // ****************************************
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    valid_prev <= bus_req.valid;
    if (bus_req.valid === 1'b1 && valid_prev !== 1'b1)
      starts <= starts + 1;
    if (berr_wr === 1'b1) begin
      berr_hits <= berr_hits + 1;
      check("berr_addr", berr_addr, 12'h067C);
      check("berr_data", berr_data, 16'h0001);
    end
    if (cycles == 5000) begin
      miscompares++;
      final_report();
    end
  end

  task automatic pwrite(input logic [11:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    pram_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk);
    pram_req.wr <= 1'b0;
  endtask

  task automatic pread(input string name, input logic [11:0] a, input logic [15:0] exp);
    @(posedge ref_clk);
    pram_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge ref_clk);
    pram_req.rd <= 1'b0;
    #1;
    check(name, pram_rdata, exp);
  endtask

  // Falling edge held past the synchroniser
  task automatic request();
    @(posedge ref_clk);
    pin <= 1'b0;
    repeat (4) @(posedge ref_clk);
    pin <= 1'b1;
  endtask

  task automatic finish_one(input logic [23:0] a);
    int n;
    int s;
    s = starts;
    n = 0;
    while (bus_req.valid !== 1'b1 && n < 30) begin
      @(posedge ref_clk);
      n++;
    end
    check("addr", bus_req.addr, a);
    check("fc", bus_req.fc, 3'h3);
    check("strobes", {bus_req.uds, bus_req.lds}, {~a[0], a[0]});
    check("bus_clear_req", bus_clear_req, 1'b1);
    n = 0;
    while (bus_req.valid !== 1'b0 && n < 40) begin
      @(posedge ref_clk);
      n++;
    end
    repeat (2) @(posedge ref_clk);
    check("cycle_count", starts - s, 1);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_params();
    pwrite(OFS_START_HIGH_FC, 16'hFFFF);
    pread("high_mask", OFS_START_HIGH_FC, 16'h70FF);
    pwrite(OFS_ROW_STEP, 16'hA5C3);
    pread("step_rb", OFS_ROW_STEP, 16'hA5C3);
    pread("unmapped", 12'h0400, 16'h0000);
    // Function code 3, never all ones
    pwrite(OFS_START_HIGH_FC, 16'h3012);
    pwrite(OFS_START_LOW, 16'hFFFF);
    pwrite(OFS_ROW_STEP, 16'h0001);
    pwrite(OFS_ROW_TOTAL, 16'h0003);
    pwrite(OFS_ROWS_LEFT, 16'h0000);
    // Descriptor word below the window must not touch the parameters
    pwrite(12'h0568, 16'hFFFF);
    pread("descriptor_slot", 12'h0568, 16'h0000);
    enable <= 1'b1;
  endtask

  task automatic t_wrap();
    for (int i = 0; i < 4; i++) begin
      wait_cycles <= 4'(i * 5);
      request();
      finish_one(START + 24'(i % 3));
      if (i == 0) begin
        pread("next_high", OFS_NEXT_HIGH_FC, 16'h3013);
        pread("next_low", OFS_NEXT_LOW, 16'h0000);
        pread("rows_left", OFS_ROWS_LEFT, 16'h0002);
      end
    end
  endtask

  task automatic t_disable();
    int s;
    s = starts;
    enable <= 1'b0;
    request();
    repeat (20) @(posedge ref_clk);
    check("disabled_starts", starts - s, 0);
    check("disabled_pending", refresh_pending, 1'b0);
    enable <= 1'b1;
  endtask

  task automatic t_exception();
    int s;
    s = starts;
    bus_exception <= 1'b1;
    request();
    repeat (10) @(posedge ref_clk);
    check("held_starts", starts - s, 0);
    check("held_pending", refresh_pending, 1'b1);
    bus_exception <= 1'b0;
    finish_one(START + 24'h00_0001);
  endtask

  task automatic t_berr();
    int h;
    h = berr_hits;
    err_en <= 1'b1;
    request();
    finish_one(START + 24'h00_0002);
    check("berr_hits", berr_hits - h, 1);
    err_en <= 1'b0;
    request();
    finish_one(START);
  endtask

  initial begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    t_params();
    t_wrap();
    t_disable();
    t_exception();
    t_berr();
    final_report();
  end
endmodule
`default_nettype wire
